// ### src/lccr_regs.svh
// Register offsets, field positions and reset values of the lane config bank
`ifndef LCCR_REGS_SVH
`define LCCR_REGS_SVH

// Register offsets
`define LCCR_OFS_SWING_A     8'h17
`define LCCR_OFS_SWING_B     8'h18
`define LCCR_OFS_B0_THRESH   8'h19
`define LCCR_OFS_A1_EQ       8'h1D
`define LCCR_OFS_A1_THRESH   8'h20
`define LCCR_OFS_IDLE_SEL    8'h23

// Reset values
`define LCCR_RST_SWING_A     8'h03
`define LCCR_RST_SWING_B     8'h03
`define LCCR_RST_THRESH      8'h00
`define LCCR_RST_EQ          8'h20
`define LCCR_RST_IDLE_SEL    8'h00

// Writable bit masks, reserved bits held at zero
`define LCCR_MASK_SWING_A    8'h7F
`define LCCR_MASK_SWING_B    8'hFF
`define LCCR_MASK_THRESH     8'h0F
`define LCCR_MASK_EQ         8'h3F
`define LCCR_MASK_IDLE_SEL   8'h30

// Field positions
`define LCCR_EQ_EN_BIT       5
`define LCCR_IDLE_AUTO_BIT   5
`define LCCR_IDLE_MAN_BIT    4

`endif

// ### src/lccr_pkg.sv
// Types shared by the lane config register bank
`default_nettype none

package lccr_pkg;

    // Idle threshold selector pair
    typedef struct packed {
        logic [1:0] deassert_sel;
        logic [1:0] assert_sel;
    } lccr_thresh_t;

    // Equalizer control field
    typedef struct packed {
        logic       eq_enable;
        logic [1:0] gain_stage;
        logic [2:0] boost_level;
    } lccr_eq_t;

    // All register state of the bank except the mute stage flip-flop
    typedef struct packed {
        logic [7:0] swing_a;
        logic [7:0] swing_b;
        logic [7:0] b0_thresh;
        logic [7:0] a1_eq;
        logic [7:0] a1_thresh;
        logic [7:0] idle_sel;
        logic [7:0] rdata;
        logic [2:0] idle_sync;
        logic       idle_det;
    } lccr_state_t;

    // Output stage state
    typedef struct packed {
        logic mute;
    } lccr_mute_state_t;

endpackage : lccr_pkg

`default_nettype wire

// ### src/lccr_idle_if.sv
// Idle control bundle passed from the register bank to the mute stage
`timescale 1ns/10ps
`default_nettype none

interface lccr_idle_if;
    logic idle_auto;
    logic idle_manual;
    logic idle_detect;
    logic mute;

    // Register bank side
    modport bank (
        output idle_auto,
        output idle_manual,
        output idle_detect,
        input  mute
    );

    // Mute stage side
    modport stage (
        input  idle_auto,
        input  idle_manual,
        input  idle_detect,
        output mute
    );
endinterface : lccr_idle_if

`default_nettype wire

// ### src/lccr_mute_ctrl.sv
// Output lane one mute selection from auto or manual idle control
`timescale 1ns/10ps
`default_nettype none

module lccr_mute_ctrl
    import lccr_pkg::*;
(
    // Clock and reset
    input  wire logic   clk_sys_in,
    input  wire logic   srst_in,
    // Idle control
    lccr_idle_if.stage  idle_io
);

    lccr_mute_state_t s_q;
    lccr_mute_state_t s_d;

    // ========================================
    // Mute decision
    // ========================================
    // Auto mode follows the idle detector, else the manual bit decides
    always_comb begin
        s_d = s_q;
        if (idle_io.idle_auto) begin
            s_d.mute = idle_io.idle_detect;
        end else begin
            s_d.mute = idle_io.idle_manual;
        end
    end

    // State register
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            s_q <= '{mute: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    assign idle_io.mute = s_q.mute;

endmodule : lccr_mute_ctrl

`default_nettype wire

// ### src/lccr_bank.sv
// Lane conditioning configuration register bank
`timescale 1ns/10ps
`default_nettype none
`include "lccr_regs.svh"

module lccr_bank
    import lccr_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_sys_in,
    input  wire logic        srst_in,
    // Register port from the management bus engine
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    input  wire logic [7:0]  reg_addr_in,
    input  wire logic [7:0]  reg_wdata_in,
    output logic      [7:0]  reg_rdata_out,
    // Idle detector on input of output lane one path
    input  wire logic        idle_detect_in,
    // Output lane zero swing controls
    output logic      [6:0]  output_lane_zero_swing_a_out,
    output logic      [7:0]  output_lane_zero_swing_b_out,
    // Input B lane zero idle thresholds
    output logic      [1:0]  input_b_lane_zero_deassert_sel_out,
    output logic      [1:0]  input_b_lane_zero_assert_sel_out,
    // Input A lane one equalizer
    output logic             input_a_lane_one_eq_enable_out,
    output logic      [1:0]  input_a_lane_one_gain_stage_out,
    output logic      [2:0]  input_a_lane_one_boost_level_out,
    // Input A lane one idle thresholds
    output logic      [1:0]  input_a_lane_one_deassert_sel_out,
    output logic      [1:0]  input_a_lane_one_assert_sel_out,
    // Output lane one idle control
    output logic             output_lane_one_idle_auto_out,
    output logic             output_lane_one_idle_manual_out,
    output logic             output_lane_one_mute_out
);

    lccr_state_t  s_q;
    lccr_state_t  s_d;
    lccr_thresh_t b0_th;
    lccr_thresh_t a1_th;
    lccr_eq_t     a1_eq;
    logic [5:0]   wr_sel;
    logic [5:0]   rd_sel;

    lccr_idle_if  idle_bus ();

    // ========================================
    // Helper functions
    // ========================================
    // Merge a write into a register, reserved bits forced to zero
    function automatic logic [7:0] wr_merge(input logic [7:0] data,
                                            input logic [7:0] mask);
        wr_merge = data & mask;
    endfunction : wr_merge

    // One select bit per mapped location; unmapped offsets give none
    function automatic logic [5:0] reg_sel(input logic [7:0] addr);
        if (addr == `LCCR_OFS_SWING_A) begin
            reg_sel = 6'h01;
        end else if (addr == `LCCR_OFS_SWING_B) begin
            reg_sel = 6'h02;
        end else if (addr == `LCCR_OFS_B0_THRESH) begin
            reg_sel = 6'h04;
        end else if (addr == `LCCR_OFS_A1_EQ) begin
            reg_sel = 6'h08;
        end else if (addr == `LCCR_OFS_A1_THRESH) begin
            reg_sel = 6'h10;
        end else if (addr == `LCCR_OFS_IDLE_SEL) begin
            reg_sel = 6'h20;
        end else begin
            reg_sel = 6'h00;
        end
    endfunction : reg_sel

    // ========================================
    // Address decode
    // ========================================
    // Each strobe qualifies its own copy of the decode
    assign wr_sel = reg_wr_in ? reg_sel(reg_addr_in) : 6'h00;
    assign rd_sel = reg_rd_in ? reg_sel(reg_addr_in) : 6'h00;

    // ========================================
    // Next state
    // ========================================
    // Byte-wide locations; unmapped addresses read zero, writes dropped
    always_comb begin
        s_d = s_q;
        // Swing A, reserved bit 7 never stored
        if (wr_sel[0]) begin
            s_d.swing_a = wr_merge(reg_wdata_in,
                                   `LCCR_MASK_SWING_A);
        end
        // Swing B, all eight bits kept
        if (wr_sel[1]) begin
            s_d.swing_b = wr_merge(reg_wdata_in,
                                   `LCCR_MASK_SWING_B);
        end
        // Input B lane zero thresholds, upper nibble dropped
        if (wr_sel[2]) begin
            s_d.b0_thresh = wr_merge(reg_wdata_in,
                                     `LCCR_MASK_THRESH);
        end
        // Equalizer code stored with bits 7:6 dropped, no table check
        if (wr_sel[3]) begin
            s_d.a1_eq = wr_merge(reg_wdata_in,
                                 `LCCR_MASK_EQ);
        end
        // Input A lane one thresholds, upper nibble dropped
        if (wr_sel[4]) begin
            s_d.a1_thresh = wr_merge(reg_wdata_in,
                                     `LCCR_MASK_THRESH);
        end
        // Idle select keeps only the auto and manual bits
        if (wr_sel[5]) begin
            s_d.idle_sel = wr_merge(reg_wdata_in,
                                    `LCCR_MASK_IDLE_SEL);
        end
        // Read data taken from the old value; holds until the next read
        if (reg_rd_in) begin
            if (rd_sel[0]) begin
                s_d.rdata = s_q.swing_a;
            end else if (rd_sel[1]) begin
                s_d.rdata = s_q.swing_b;
            end else if (rd_sel[2]) begin
                s_d.rdata = s_q.b0_thresh;
            end else if (rd_sel[3]) begin
                s_d.rdata = s_q.a1_eq;
            end else if (rd_sel[4]) begin
                s_d.rdata = s_q.a1_thresh;
            end else if (rd_sel[5]) begin
                s_d.rdata = s_q.idle_sel;
            end else begin
                s_d.rdata = 8'h00;
            end
        end
        // Idle detector: three stages, a level counts once two and three agree
        s_d.idle_sync = {s_q.idle_sync[1:0], idle_detect_in};
        if (s_q.idle_sync[1] == s_q.idle_sync[2]) begin
            s_d.idle_det = s_q.idle_sync[2];
        end
    end

    // ========================================
    // State register
    // ========================================
    // Reset values select 600 mV swing, 00 thresholds, equalizer enabled at zero gain and boost
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            s_q.swing_a   <= `LCCR_RST_SWING_A;
            s_q.swing_b   <= `LCCR_RST_SWING_B;
            s_q.b0_thresh <= `LCCR_RST_THRESH;
            s_q.a1_eq     <= `LCCR_RST_EQ;
            s_q.a1_thresh <= `LCCR_RST_THRESH;
            s_q.idle_sel  <= `LCCR_RST_IDLE_SEL;
            s_q.rdata     <= 8'h00;
            s_q.idle_sync <= 3'h0;
            s_q.idle_det  <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    // ========================================
    // Field decode
    // ========================================
    // Typed views of the threshold and equalizer bytes
    assign b0_th = lccr_thresh_t'(s_q.b0_thresh[3:0]);
    assign a1_th = lccr_thresh_t'(s_q.a1_thresh[3:0]);
    assign a1_eq = lccr_eq_t'(s_q.a1_eq[5:0]);

    // Idle control into the mute stage
    assign idle_bus.idle_auto   = s_q.idle_sel[`LCCR_IDLE_AUTO_BIT];
    assign idle_bus.idle_manual = s_q.idle_sel[`LCCR_IDLE_MAN_BIT];
    assign idle_bus.idle_detect = s_q.idle_det;

    // Mute stage for output lane one
    lccr_mute_ctrl u_mute (
        .clk_sys_in (clk_sys_in),
        .srst_in    (srst_in),
        .idle_io    (idle_bus)
    );

    // ========================================
    // Outputs, all straight from flip-flops
    // ========================================
    // Register read data
    assign reg_rdata_out                      = s_q.rdata;

    // Output lane zero swing, reserved bit 7 not driven out
    assign output_lane_zero_swing_a_out       = s_q.swing_a[6:0];
    assign output_lane_zero_swing_b_out       = s_q.swing_b;

    // Input B lane zero idle thresholds
    assign input_b_lane_zero_deassert_sel_out = b0_th.deassert_sel;
    assign input_b_lane_zero_assert_sel_out   = b0_th.assert_sel;

    // Input A lane one equalizer
    assign input_a_lane_one_eq_enable_out     = a1_eq.eq_enable;
    assign input_a_lane_one_gain_stage_out    = a1_eq.gain_stage;
    assign input_a_lane_one_boost_level_out   = a1_eq.boost_level;

    // Input A lane one idle thresholds
    assign input_a_lane_one_deassert_sel_out  = a1_th.deassert_sel;
    assign input_a_lane_one_assert_sel_out    = a1_th.assert_sel;

    // Output lane one idle control and mute
    assign output_lane_one_idle_auto_out      = idle_bus.idle_auto;
    assign output_lane_one_idle_manual_out    = idle_bus.idle_manual;
    assign output_lane_one_mute_out           = idle_bus.mute;

endmodule : lccr_bank

`default_nettype wire

// ### sim/lccr_host_model.sv
// Management host model issuing byte register cycles
`timescale 1ns/10ps
`default_nettype none

module lccr_host_model (
    // Clock
    input  wire logic       clk_sys_in,
    // Register port
    output var logic        reg_wr_out,
    output var logic        reg_rd_out,
    output var logic  [7:0] reg_addr_out,
    output var logic  [7:0] reg_wdata_out,
    input  wire logic [7:0] reg_rdata_in
);
    // Bus idle at time zero
    initial begin
        reg_wr_out = 1'b0;
        reg_rd_out = 1'b0;
        reg_addr_out = 8'h00;
        reg_wdata_out = 8'h00;
    end

    // One-cycle write strobe; released lines carry inverted values
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys_in);
        reg_wr_out = 1'b1;
        reg_addr_out = a;
        reg_wdata_out = d;
        @(negedge clk_sys_in);
        reg_wr_out = 1'b0;
        reg_addr_out = ~a;
        reg_wdata_out = ~d;
    endtask : wr_reg

    // One-cycle read strobe; data taken one cycle later
    task automatic rd_reg(input logic [7:0] a,
                          output logic [7:0] d);
        @(negedge clk_sys_in);
        reg_rd_out = 1'b1;
        reg_addr_out = a;
        @(negedge clk_sys_in);
        reg_rd_out = 1'b0;
        reg_addr_out = ~a;
        d = reg_rdata_in;
    endtask : rd_reg

    // Partial update keeps other fields, reserved bits go out as zero
    task automatic rmw(input logic [7:0] a, input logic [7:0] keep,
                       input logic [7:0] set,
                       input logic [7:0] msk);
        logic [7:0] v;
        rd_reg(a, v);
        wr_reg(a, ((v & keep) | set) & msk);
    endtask : rmw
endmodule : lccr_host_model

`default_nettype wire

// ### sim/lccr_bank_monitor.sv
// Checker of the lane config register bank ports
`timescale 1ns/10ps
`default_nettype none

module lccr_bank_monitor (
    // Clock, reset and register port
    input wire logic       clk_sys_in,
    input wire logic       srst_in,
    input wire logic       reg_wr_in,
    input wire logic       reg_rd_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic [7:0] reg_rdata_out,
    input wire logic       idle_detect_in,
    // Field outputs
    input wire logic [6:0] output_lane_zero_swing_a_out,
    input wire logic [1:0] input_b_lane_zero_deassert_sel_out,
    input wire logic [1:0] input_b_lane_zero_assert_sel_out,
    input wire logic       input_a_lane_one_eq_enable_out,
    input wire logic [1:0] input_a_lane_one_gain_stage_out,
    input wire logic [2:0] input_a_lane_one_boost_level_out,
    input wire logic       output_lane_one_idle_auto_out,
    input wire logic       output_lane_one_idle_manual_out,
    input wire logic       output_lane_one_mute_out
);
    // Short views of grouped fields
    wire logic [5:0] eq_w = {input_a_lane_one_eq_enable_out,
        input_a_lane_one_gain_stage_out, input_a_lane_one_boost_level_out};
    wire logic       auto_w = output_lane_one_idle_auto_out;
    wire logic       man_w = output_lane_one_idle_manual_out;
    wire logic       mute_w = output_lane_one_mute_out;

    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (srst_in);

    // Detector held steady in auto mode long enough to pass the synchroniser
    sequence s_idle_seen;
        (auto_w && idle_detect_in)[*6];
    endsequence
    sequence s_busy_seen;
        (auto_w && !idle_detect_in)[*6];
    endsequence

    AST_RD_SWING: assert property (
        reg_rd_in && reg_addr_in == 8'h17 |=> reg_rdata_out ==
        {1'b0, $past(output_lane_zero_swing_a_out)}) else $error("swing read");
    AST_RD_EQ: assert property (
        reg_rd_in && reg_addr_in == 8'h1D |=> reg_rdata_out ==
        {2'b00, $past(eq_w)}) else $error("equalizer read");
    AST_RD_UNMAPPED: assert property (
        reg_rd_in && !(reg_addr_in inside {8'h17, 8'h18, 8'h19, 8'h1D, 8'h20,
        8'h23}) |=> reg_rdata_out == 8'h00) else $error("unmapped read");
    AST_WR_SWING: assert property (
        reg_wr_in && reg_addr_in == 8'h17 |=> output_lane_zero_swing_a_out ==
        $past(reg_wdata_in[6:0])) else $error("swing write");
    AST_WR_EQ: assert property (
        reg_wr_in && reg_addr_in == 8'h1D |=> eq_w == $past(reg_wdata_in[5:0]))
        else $error("equalizer write");
    AST_WR_THRESH: assert property (
        reg_wr_in && reg_addr_in == 8'h19 |=>
        {input_b_lane_zero_deassert_sel_out,
        input_b_lane_zero_assert_sel_out} == $past(reg_wdata_in[3:0]))
        else $error("threshold write");
    AST_WR_IDLE: assert property (
        reg_wr_in && reg_addr_in == 8'h23 |=> {auto_w, man_w} ==
        $past(reg_wdata_in[5:4])) else $error("idle select write");
    AST_MAN_MUTE: assert property (
        !$past(auto_w) |-> mute_w == $past(man_w)) else $error("manual mute");
    AST_AUTO_MUTE: assert property (
        s_idle_seen |-> mute_w) else $error("auto mute missing");
    AST_AUTO_OPEN: assert property (
        s_busy_seen |-> !mute_w) else $error("auto unmute missing");
endmodule : lccr_bank_monitor

bind lccr_bank lccr_bank_monitor lccr_bank_monitor_inst (
    .clk_sys_in                         (clk_sys_in),
    .srst_in                            (srst_in),
    .reg_wr_in                          (reg_wr_in),
    .reg_rd_in                          (reg_rd_in),
    .reg_addr_in                        (reg_addr_in),
    .reg_wdata_in                       (reg_wdata_in),
    .reg_rdata_out                      (reg_rdata_out),
    .idle_detect_in                     (idle_detect_in),
    .output_lane_zero_swing_a_out       (output_lane_zero_swing_a_out),
    .input_b_lane_zero_deassert_sel_out (input_b_lane_zero_deassert_sel_out),
    .input_b_lane_zero_assert_sel_out   (input_b_lane_zero_assert_sel_out),
    .input_a_lane_one_eq_enable_out     (input_a_lane_one_eq_enable_out),
    .input_a_lane_one_gain_stage_out    (input_a_lane_one_gain_stage_out),
    .input_a_lane_one_boost_level_out   (input_a_lane_one_boost_level_out),
    .output_lane_one_idle_auto_out      (output_lane_one_idle_auto_out),
    .output_lane_one_idle_manual_out    (output_lane_one_idle_manual_out),
    .output_lane_one_mute_out           (output_lane_one_mute_out)
);

`default_nettype wire

// ### sim/test_lccr_bank.sv
// Self-checking testbench of the lane config register bank
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin mismatches++; \
    $display("ERROR %0t: got %h want %h", $time, a, b); end end

module test_lccr_bank;
    logic       clk_sys_in = 1'b0;
    logic       srst_in = 1'b1;
    logic       idle_det = 1'b0;
    logic       wr, rd, en, auto, man, mute;
    logic [7:0] addr, wdata, rdata, sw_b, v, d;
    logic [6:0] sw_a;
    logic [2:0] boost;
    logic [1:0] b_ds, b_as, gain, a_ds, a_as;
    logic [7:0] sh [6];
    int         mismatches = 0, checks_done = 0, cycles = 0, n, idx;
    integer     seed = 32'h0C5E;
    localparam logic [7:0] ADR [6] = '{8'h17, 8'h18, 8'h19, 8'h1D, 8'h20,
                                       8'h23};
    localparam logic [7:0] RST [6] = '{8'h03, 8'h03, 8'h00, 8'h20, 8'h00,
                                       8'h00};
    localparam logic [7:0] MSK [6] = '{8'h7F, 8'hFF, 8'h0F, 8'h3F, 8'h0F,
                                       8'h30};
    localparam logic [7:0] CRN [6] = '{8'h2A, 8'h30, 8'h32, 8'h3B, 8'h87,
                                       8'hFF};
    localparam int         CIX [6] = '{3, 3, 3, 3, 0, 2};

    lccr_bank lccr_bank_inst (
        .clk_sys_in(clk_sys_in), .srst_in(srst_in),
        .reg_wr_in(wr), .reg_rd_in(rd), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_rdata_out(rdata), .idle_detect_in(idle_det),
        .output_lane_zero_swing_a_out(sw_a),
        .output_lane_zero_swing_b_out(sw_b),
        .input_b_lane_zero_deassert_sel_out(b_ds),
        .input_b_lane_zero_assert_sel_out(b_as),
        .input_a_lane_one_eq_enable_out(en),
        .input_a_lane_one_gain_stage_out(gain),
        .input_a_lane_one_boost_level_out(boost),
        .input_a_lane_one_deassert_sel_out(a_ds),
        .input_a_lane_one_assert_sel_out(a_as),
        .output_lane_one_idle_auto_out(auto),
        .output_lane_one_idle_manual_out(man),
        .output_lane_one_mute_out(mute));
    lccr_host_model lccr_host_model_inst (.clk_sys_in(clk_sys_in),
        .reg_wr_out(wr), .reg_rd_out(rd), .reg_addr_out(addr),
        .reg_wdata_out(wdata), .reg_rdata_in(rdata));

    // Clock and hang guard
    always #50 clk_sys_in = ~clk_sys_in;
    always @(posedge clk_sys_in) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            give_verdict();
        end
    end

    // Register value after write: reserved bits read back as zero
    function automatic logic [7:0] exp_rd(int i, logic [7:0] x);
        return x & MSK[i];
    endfunction : exp_rd

    // Field outputs against the shadow copy
    task automatic chk_fields();
        `CHK(sw_a, sh[0][6:0])
        `CHK(sw_b, sh[1])
        `CHK({b_ds, b_as}, sh[2][3:0])
        `CHK({en, gain, boost}, sh[3][5:0])
        `CHK({a_ds, a_as}, sh[4][3:0])
        `CHK({auto, man}, sh[5][5:4])
    endtask : chk_fields

    task automatic give_verdict();
        $display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : give_verdict

    // Reset, defaults, unmapped place, corner and random writes, idle paths
    initial begin
        repeat (5) @(posedge clk_sys_in);
        @(negedge clk_sys_in);
        srst_in = 1'b0;
        for (n = 0; n < 6; n++) begin
            lccr_host_model_inst.rd_reg(ADR[n], v);
            sh[n] = RST[n];
            `CHK(v, RST[n])
        end
        chk_fields();
        `CHK(mute, 1'b0)
        lccr_host_model_inst.wr_reg(8'h1A, 8'hFF);
        lccr_host_model_inst.rd_reg(8'h1A, v);
        `CHK(v, 8'h00)
        for (n = 0; n < 60; n++) begin
            idx = (n < 6) ? CIX[n] : $unsigned($random(seed)) % 6;
            d = (n < 6) ? CRN[n] : 8'($random(seed));
            idle_det = 1'($random(seed));
            lccr_host_model_inst.wr_reg(ADR[idx], d);
            lccr_host_model_inst.rd_reg(ADR[idx], v);
            sh[idx] = exp_rd(idx, d);
            `CHK(v, sh[idx])
            chk_fields();
        end
        idle_det = 1'b1;
        lccr_host_model_inst.wr_reg(8'h23, 8'h10);
        repeat (2) @(negedge clk_sys_in);
        `CHK(mute, 1'b1)
        lccr_host_model_inst.wr_reg(8'h23, 8'h00);
        repeat (2) @(negedge clk_sys_in);
        `CHK(mute, 1'b0)
        lccr_host_model_inst.rmw(8'h23, 8'h10, 8'h20, 8'h30);
        repeat (8) @(negedge clk_sys_in);
        `CHK(mute, 1'b1)
        idle_det = 1'b0;
        repeat (8) @(negedge clk_sys_in);
        `CHK(mute, 1'b0)
        give_verdict();
    end
endmodule : test_lccr_bank

`default_nettype wire
